// *** sim/host_model.sv ***
// host processor model: memory accesses and commands
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic       clock,
	input  wire logic [7:0] memRdata,
	output var  logic       memWrite,
	output var  logic       memRead,
	output var  logic [9:0] memAddr,
	output var  logic [7:0] memWdata,
	output wire logic       enterReceiveCmd,
	output wire logic       enterTransmitCmd,
	output wire logic       sleepCmd,
	output wire logic       applyConfigCmd
);
	logic [3:0] cmdQ = 4'h0;
	logic [7:0] bandQ;
	logic [7:0] amplQ;
	assign {applyConfigCmd, sleepCmd, enterTransmitCmd, enterReceiveCmd} = cmdQ;
	initial
	begin
		memWrite = 1'b0;
		memRead = 1'b0;
		memAddr = 10'h000;
		memWdata = 8'h00;
	end
	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 memAddr = a;
		memWdata = d;
		memWrite = 1'b1;
		@(posedge clock);
		#1 memWrite = 1'b0;
		memWdata = ~d;
	endtask
	task rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clock);
		#1 memAddr = a;
		memRead = 1'b1;
		@(posedge clock);
		#1 d = memRdata;
		memRead = 1'b0;
	endtask
	// 0 receive, 1 transmit, 2 sleep, 3 apply
	task cmd(input int k);
		@(posedge clock);
		#1 cmdQ = 4'h1 << k;
		@(posedge clock);
		#1 cmdQ = 4'h0;
	endtask
	function automatic logic [7:0] lookupVal(input int i, input logic fast);
		case (i)
			0, 1: return fast ? 8'h20 : 8'h10;
			5: return fast ? 8'h05 : 8'h0F;
			2, 3: return 8'h0F;
			4, 6: return 8'h1F;
			7: return 8'h33;
			default: return 8'h22;
		endcase
	endfunction
	task lookup_load(input logic fast);
		for (int i = 0; i < 9; i++)
			wr(10'h010 + 10'(i), lookupVal(i, fast));
	endtask
	task cfg_opt();
		wr(10'h113, 8'h20);
		cmd(3);
	endtask
	task store_cal();
		rd(10'h3DA, bandQ);
		rd(10'h3DB, amplQ);
	endtask
	task bypass(input logic [7:0] b, input logic [7:0] a);
		wr(10'h3CD, 8'h03);
		wr(10'h3D0, 8'h0F);
		wr(10'h3CB, b);
		wr(10'h3CC, a);
		wr(10'h338, 8'h00);
		wr(10'h338, 8'h01);
	endtask
endmodule // host_model
`default_nettype wire

// *** sim/synth_cal_settle_sequencer_test.sv ***
// self-checking bench for the synthesizer sequencer
`timescale 1ns/1ps
`default_nettype none
module synth_cal_settle_sequencer_test;
	localparam int CAL = 20;
	localparam int SET = 10;
	logic        clock;
	logic        nrst;
	logic        ce;
	logic [11:0] dataRate;
	logic [7:0]  calBandIn;
	logic [7:0]  calAmplitudeIn;
	wire         memWrite, memRead, rxCmd, txCmd, slpCmd, cfgCmd;
	wire  [9:0]  memAddr;
	wire  [7:0]  memWdata, memRdata, vcoBand, vcoAmplitude;
	wire  [2:0]  seqState, loopBandwidth;
	wire         calRunning, receiveState, transmitState, sleepState, gaussianEnable;
	wire         optimizedTxBw;
	int          err_total = 0;
	int          total_checks = 0;
	int          lat;
	logic        saw;
	logic [31:0] seed = 32'd57;
	logic [7:0]  x, b, a;
	logic [31:0] v;
	logic [11:0] rates [12];
	synth_cal_settle_sequencer #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET)) u_dut
	(.clock(clock), .nrst(nrst), .ce(ce), .memWrite(memWrite), .memRead(memRead),
	.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
	.enterReceiveCmd(rxCmd), .enterTransmitCmd(txCmd), .sleepCmd(slpCmd),
	.applyConfigCmd(cfgCmd), .dataRate(dataRate), .calBandIn(calBandIn),
	.calAmplitudeIn(calAmplitudeIn), .seqState(seqState), .loopBandwidth(loopBandwidth),
	.calRunning(calRunning), .receiveState(receiveState), .transmitState(transmitState),
	.sleepState(sleepState), .gaussianEnable(gaussianEnable),
	.optimizedTxBw(optimizedTxBw), .vcoBand(vcoBand), .vcoAmplitude(vcoAmplitude));
	host_model u_host
	(.clock(clock), .memRdata(memRdata), .memWrite(memWrite), .memRead(memRead),
	.memAddr(memAddr), .memWdata(memWdata), .enterReceiveCmd(rxCmd),
	.enterTransmitCmd(txCmd), .sleepCmd(slpCmd), .applyConfigCmd(cfgCmd));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [2:0] expBw(input logic [11:0] r);
		if (r <= 12'd495) return 3'h1;
		if (r <= 12'd1295) return 3'h2;
		if (r <= 12'd1791) return 3'h3;
		if (r <= 12'd2399) return 3'h4;
		return 3'h5;
	endfunction
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// waits for the target state, counting cycles and watching calibration
	task wst(input int k);
		lat = 0;
		saw = 1'b0;
		while ((k == 0 ? receiveState : transmitState) !== 1'b1 && lat < 2000)
		begin
			@(posedge clock);
			#1 lat++;
			saw = saw | (calRunning !== 1'b0);
		end
	endtask
	task enter(input int k, input int lo);
		u_host.cmd(k);
		wst(k);
		check("entry latency", lat >= lo && lat <= lo + 4, 1);
	endtask
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		dataRate = 12'd100;
		calBandIn = 8'h00;
		calAmplitudeIn = 8'h00;
		repeat (20) @(posedge clock);
		#1 nrst = 1'b1;
		v = rnd();
		u_host.wr(10'h13E, v[7:0]);
		u_host.rd(10'h13E, x);
		check("rx delay reg", x, v[7:0]);
		ce = 1'b0;
		u_host.wr(10'h13E, ~v[7:0]);
		ce = 1'b1;
		u_host.rd(10'h13E, x);
		check("frozen write", x, v[7:0]);
		u_host.rd(10'h200, x);
		check("unmapped read", x, 0);
		u_host.wr(10'h115, v[15:8]);
		repeat (3) @(posedge clock);
		#1 check("gaussian enable", gaussianEnable, v[12]);
		u_host.lookup_load(v[16]);
		for (int i = 0; i < 9; i++)
		begin
			u_host.rd(10'h010 + 10'(i), x);
			check("lookup entry", x, u_host.lookupVal(i, v[16]));
		end
		u_host.cmd(2);
		repeat (2) @(posedge clock);
		#1 check("sleep state", sleepState, 1);
		u_host.rd(10'h012, x);
		check("lookup after sleep", x, 0);
		u_host.cfg_opt();
		repeat (2) @(posedge clock);
		#1 check("optimized tx bw", optimizedTxBw, 1);
		$display("test registers done");
		v = rnd();
		calBandIn = v[7:0];
		calAmplitudeIn = v[15:8];
		u_host.cmd(0);
		u_host.rd(10'h339, x);
		check("cal busy bit", x[1], 1);
		wst(0);
		u_host.rd(10'h339, x);
		check("cal done bits", x[1:0], 2'b01);
		check("rx bandwidth", loopBandwidth, 0);
		u_host.store_cal();
		check("band result", u_host.bandQ, calBandIn);
		check("amplitude result", u_host.amplQ, calAmplitudeIn);
		$display("test calibrated receive done");
		rates = '{12'd1, 12'd495, 12'd496, 12'd1295, 12'd1296, 12'd1791,
			12'd1792, 12'd2399, 12'd2400, 12'd3000, 12'd0, 12'd0};
		for (int i = 0; i < 12; i++)
		begin
			dataRate = (i >= 10) ? 12'(rnd() % 3000 + 1) : rates[i];
			enter(1, CAL + SET);
			check("tx bandwidth", loopBandwidth, expBw(dataRate));
			enter(0, CAL + SET);
			check("rx bandwidth", loopBandwidth, 0);
		end
		$display("test bandwidth table done");
		u_host.wr(10'h11A, 8'h08);
		u_host.wr(10'h13E, 8'h00);
		u_host.wr(10'h13F, 8'h01);
		enter(0, CAL + 250);
		enter(1, CAL + 500);
		u_host.wr(10'h11A, 8'h00);
		enter(0, CAL + SET);
		$display("test custom settle done");
		v = rnd();
		b = v[7:0];
		a = v[15:8];
		calBandIn = ~b;
		calAmplitudeIn = ~a;
		u_host.bypass(b, a);
		enter(1, SET);
		check("no calibration", saw, 0);
		check("band override", vcoBand, b);
		check("amplitude override", vcoAmplitude, a);
		u_host.rd(10'h339, x);
		check("bypassed bit", x[2], 1);
		enter(0, CAL + SET);
		check("calibrated again", saw, 1);
		$display("test bypass done");
		finish_test();
	end
endmodule // synth_cal_settle_sequencer_test
`default_nettype wire

// *** sim/synth_seq_monitor.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module synth_seq_monitor
#(
	parameter CAL_CYCLES    = 20,
	parameter SETTLE_CYCLES = 10
)
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic        memWrite,
	input wire logic        memRead,
	input wire logic [9:0]  memAddr,
	input wire logic [7:0]  memWdata,
	input wire logic [7:0]  memRdata,
	input wire logic        enterReceiveCmd,
	input wire logic        enterTransmitCmd,
	input wire logic [11:0] dataRate,
	input wire logic [2:0]  seqState,
	input wire logic [2:0]  loopBandwidth,
	input wire logic        calRunning,
	input wire logic        receiveState,
	input wire logic        transmitState
);
	logic [2:0]  prev_q;
	logic [15:0] cnt_q;
	logic        custom_q;
	function automatic logic [2:0] bwFor(input logic [11:0] r);
		if (r <= 12'd495) return 3'h1;
		if (r <= 12'd1295) return 3'h2;
		if (r <= 12'd1791) return 3'h3;
		if (r <= 12'd2399) return 3'h4;
		return 3'h5;
	endfunction
	// cycles spent in the present state
	always @(posedge clock)
	begin
		prev_q <= seqState;
		cnt_q <= (!nrst || seqState != prev_q) ? 16'h1 : cnt_q + 16'h1;
		if (!nrst)
			custom_q <= 1'b0;
		else if (ce && memWrite && memAddr == 10'h11A)
			custom_q <= memWdata[3];
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_cmd_starts_cal: assert property (
		(ce && (enterReceiveCmd || enterTransmitCmd) && (seqState == 0 || seqState >= 3))
		|=> (seqState == 1 || seqState == 2)) else $error("command not taken");
	a_cal_flag_state: assert property (
		calRunning == (seqState == 3'h1)) else $error("cal flag off state");
	a_cal_status_read: assert property (
		(ce && memRead && memAddr == 10'h339) |=> memRdata[1] == $past(calRunning))
		else $error("busy bit wrong");
	a_cal_length: assert property (
		(seqState == 2 && prev_q == 1) |-> (cnt_q + 2 >= CAL_CYCLES && cnt_q <= CAL_CYCLES + 2))
		else $error("cal length wrong");
	a_cal_then_settle: assert property (
		$fell(calRunning) |-> seqState == 3'h2) else $error("no settle after cal");
	a_settle_default: assert property (
		(prev_q == 2 && seqState >= 3 && !custom_q)
		|-> (cnt_q + 2 >= SETTLE_CYCLES && cnt_q <= SETTLE_CYCLES + 4))
		else $error("default settle wrong");
	a_settle_custom: assert property (
		(prev_q == 2 && seqState >= 3 && custom_q) |-> cnt_q >= 16'd248)
		else $error("custom settle short");
	a_rx_bw_narrow: assert property (
		$rose(receiveState) |-> loopBandwidth == 3'h0) else $error("rx bandwidth wrong");
	a_tx_bw_rate: assert property (
		$rose(transmitState) |-> loopBandwidth == bwFor(dataRate))
		else $error("tx bandwidth wrong");
	a_entry_after_settle: assert property (
		$rose(receiveState || transmitState) |-> $past(seqState) == 3'h2)
		else $error("entry without settle");
	cover property ($rose(receiveState));
	cover property ($rose(transmitState) && loopBandwidth == 3'h5);
	cover property (seqState == 2 && prev_q >= 3);
endmodule // synth_seq_monitor
bind synth_cal_settle_sequencer synth_seq_monitor
#(.CAL_CYCLES(CAL_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon
(.clock(clock), .nrst(nrst), .ce(ce), .memWrite(memWrite), .memRead(memRead),
.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
.enterReceiveCmd(enterReceiveCmd), .enterTransmitCmd(enterTransmitCmd),
.dataRate(dataRate), .seqState(seqState), .loopBandwidth(loopBandwidth),
.calRunning(calRunning), .receiveState(receiveState), .transmitState(transmitState));
`default_nettype wire

// *** verilog/settle_timer.v ***
// down-counter that times calibration and settling phases
`timescale 1ns/1ps
`default_nettype none

module settle_timer
(
	input  wire        clock,
	input  wire        nrst,
	input  wire        ce,
	input  wire        load,
	input  wire [15:0] loadCount,
	output wire        busy,
	output reg         done
);

	reg [15:0] count_q;

	assign busy = (count_q != 16'h0000);

	always @(posedge clock)
	begin
		if (!nrst)
		begin
			count_q <= 16'h0000;
			done    <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (load)
				count_q <= loadCount;
			else if (busy)
			begin
				count_q <= count_q - 16'h0001;
				if (count_q == 16'h0001)
					done <= 1'b1;
			end
		end
	end

endmodule // settle_timer

`default_nettype wire

// *** verilog/synth_cal_settle_sequencer.v ***
// synthesizer calibration, settling and loop bandwidth sequencer
// What this block does
// R1: receive or transmit command starts oscillator calibration unless bypass is set up and the command arrives outside sleep.
// R2: calibration lasts 142 us; completion shows in the calibration progress register.
// R3: after calibration a settling wait follows, 56 us by default.
// R4: custom settle enable bit set selects programmable settling delays.
// R5: receive and transmit settling delays come from their own registers.
// R6: programmable delay spans 2 to 512 us in 2 us steps.
// R7: loop bandwidth is chosen automatically on entering receive or transmit.
// R8: receive entry always applies the 92 kHz narrow bandwidth.
// R9: transmit entry picks 130/174/226/305/382 kHz from the data rate.
// R10: Gaussian shaping filter, BT 0.5, enabled from radio configuration nine.
// R11: host writes 0x2 to configuration seven bits 5:4, then apply command.
// R12: host loads nine lookup entries at 0x010 to 0x018 by block write.
// R13: lookup contents depend on rate; host supplies the right values.
// R14: lookup table kept while powered, lost on sleep; host rewrites it.
// R15: host stores band and amplitude results after a calibrated entry.
// R16: host sets override enables 0x3 and calibration config 0x0F for bypass.
// R17: clearing then setting synth calibration enable arms a bypassed entry.
// R18: state is entered only after calibration or bypass and settling finish.
`timescale 1ns/1ps
`default_nettype none
`include "synth_seq_map.vh"

module synth_cal_settle_sequencer
#(
	parameter CAL_CYCLES    = `CAL_TIME_US * `CLK_MHZ,
	parameter SETTLE_CYCLES = `SETTLE_DEFAULT_US * `CLK_MHZ
)
(
	input  wire        clock,
	input  wire        nrst,
	input  wire        ce,
	input  wire        memWrite,
	input  wire        memRead,
	input  wire [9:0]  memAddr,
	input  wire [7:0]  memWdata,
	output reg  [7:0]  memRdata,
	input  wire        enterReceiveCmd,
	input  wire        enterTransmitCmd,
	input  wire        sleepCmd,
	input  wire        applyConfigCmd,
	input  wire [11:0] dataRate,
	input  wire [7:0]  calBandIn,
	input  wire [7:0]  calAmplitudeIn,
	output reg  [2:0]  seqState,
	output reg  [2:0]  loopBandwidth,
	output reg         calRunning,
	output reg         receiveState,
	output reg         transmitState,
	output reg         sleepState,
	output reg         gaussianEnable,
	output reg         optimizedTxBw,
	output reg  [7:0]  vcoBand,
	output reg  [7:0]  vcoAmplitude
);

	localparam integer STEP_CYCLES  = `SETTLE_STEP_US * `CLK_MHZ;
	localparam [15:0]  CAL_COUNT    = CAL_CYCLES[15:0];
	localparam [15:0]  SETTLE_COUNT = SETTLE_CYCLES[15:0];
	localparam [15:0]  STEP_COUNT   = STEP_CYCLES[15:0];
	////////////////////////////////////////////////////////////////////////////////
	// helpers
	// transmit bandwidth from data rate in 100 bps units
	function [2:0] txBandwidth;
		input [11:0] rate;
		begin
			if (rate <= `RATE_LIMIT_0)
				txBandwidth = `BW_TX_130K;
			else if (rate <= `RATE_LIMIT_1)
				txBandwidth = `BW_TX_174K;
			else if (rate <= `RATE_LIMIT_2)
				txBandwidth = `BW_TX_226K;
			else if (rate <= `RATE_LIMIT_3)
				txBandwidth = `BW_TX_305K;
			else
				txBandwidth = `BW_TX_382K;
		end
	endfunction

	// custom delay: count n gives (n + 1) steps of 2 us
	function [15:0] customDelay;
		input [7:0] steps;
		reg   [23:0] product;
		begin
			product     = ({16'h0000, steps} + 24'h000001) * {8'h00, STEP_COUNT};
			customDelay = product[15:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] radioConfigSeven_q;
	reg [7:0] radioConfigNine_q;
	reg [7:0] operatingOptions_q;
	reg [7:0] rxSettleDelay_q;
	reg [7:0] txSettleDelay_q;
	reg [7:0] calTriggerControl_q;
	reg [7:0] bandOverrideValue_q;
	reg [7:0] amplitudeOverrideValue_q;
	reg [7:0] overrideEnables_q;
	reg [7:0] oscCalConfig_q;
	reg [7:0] bandResult_q;
	reg [7:0] amplitudeResult_q;
	reg [7:0] lookupTable_q [0:`LOOKUP_ENTRIES-1];
	reg       bypassArmed_q;
	reg       calDone_q;
	reg       bypassed_q;
	reg       targetTransmit_q;
	wire       regWrite = ce & memWrite;
	wire       lookupHit = (memAddr >= `ADDR_LOOKUP_FIRST) && (memAddr <= `ADDR_LOOKUP_LAST);
	wire [3:0] lookupIndex = memAddr[3:0];
	wire       synthCalEnableBit = memWdata[`BIT_SYNTH_CAL_ENABLE];
	wire       calTriggerWrite = regWrite && (memAddr == `ADDR_CAL_TRIGGER_CONTROL);
	wire       bypassConfigured = (overrideEnables_q == `OVERRIDE_ENABLES_BYPASS) &&
		(oscCalConfig_q == `OSC_CAL_CONFIG_BYPASS);
	wire       customSettle = operatingOptions_q[`BIT_CUSTOM_SETTLE_ENABLE];
	integer    i;

	always @(posedge clock)
	begin
		if (!nrst)
		begin
			radioConfigSeven_q       <= `REG_RESET;
			radioConfigNine_q        <= `REG_RESET;
			operatingOptions_q       <= `REG_RESET;
			rxSettleDelay_q          <= `REG_RESET;
			txSettleDelay_q          <= `REG_RESET;
			calTriggerControl_q      <= `REG_RESET;
			bandOverrideValue_q      <= `REG_RESET;
			amplitudeOverrideValue_q <= `REG_RESET;
			overrideEnables_q        <= `REG_RESET;
			oscCalConfig_q           <= `REG_RESET;
			for (i = 0; i < `LOOKUP_ENTRIES; i = i + 1)
				lookupTable_q[i] <= `REG_RESET;
		end
		else if (ce)
		begin
			if (sleepCmd)
			begin
				for (i = 0; i < `LOOKUP_ENTRIES; i = i + 1)
					lookupTable_q[i] <= `REG_RESET; // R14
			end
			else if (memWrite && lookupHit)
				lookupTable_q[lookupIndex - 4'h0] <= memWdata; // R12
			if (memWrite)
			begin
				case (memAddr)
					`ADDR_RADIO_CONFIG_SEVEN:       radioConfigSeven_q <= memWdata;
					`ADDR_RADIO_CONFIG_NINE:        radioConfigNine_q <= memWdata;
					`ADDR_OPERATING_OPTIONS:        operatingOptions_q <= memWdata;
					`ADDR_RX_SETTLE_DELAY:          rxSettleDelay_q <= memWdata;
					`ADDR_TX_SETTLE_DELAY:          txSettleDelay_q <= memWdata;
					`ADDR_CAL_TRIGGER_CONTROL:      calTriggerControl_q <= memWdata;
					`ADDR_BAND_OVERRIDE_VALUE:      bandOverrideValue_q <= memWdata;
					`ADDR_AMPLITUDE_OVERRIDE_VALUE: amplitudeOverrideValue_q <= memWdata;
					`ADDR_OVERRIDE_ENABLES:         overrideEnables_q <= memWdata;
					`ADDR_OSC_CAL_CONFIG:           oscCalConfig_q <= memWdata;
					default:                        ;
				endcase
			end
		end
	end
	// read port, registered
	always @(posedge clock)
	begin
		if (!nrst)
			memRdata <= `REG_RESET;
		else if (ce && memRead)
		begin
			if (lookupHit)
				memRdata <= lookupTable_q[lookupIndex];
			else
			begin
				case (memAddr)
					`ADDR_RADIO_CONFIG_SEVEN:       memRdata <= radioConfigSeven_q;
					`ADDR_RADIO_CONFIG_NINE:        memRdata <= radioConfigNine_q;
					`ADDR_OPERATING_OPTIONS:        memRdata <= operatingOptions_q;
					`ADDR_RX_SETTLE_DELAY:          memRdata <= rxSettleDelay_q;
					`ADDR_TX_SETTLE_DELAY:          memRdata <= txSettleDelay_q;
					`ADDR_CAL_TRIGGER_CONTROL:      memRdata <= calTriggerControl_q;
					`ADDR_CAL_PROGRESS:             memRdata <= {5'h00, bypassed_q,
						calRunning, calDone_q}; // R2
					`ADDR_BAND_OVERRIDE_VALUE:      memRdata <= bandOverrideValue_q;
					`ADDR_AMPLITUDE_OVERRIDE_VALUE: memRdata <= amplitudeOverrideValue_q;
					`ADDR_OVERRIDE_ENABLES:         memRdata <= overrideEnables_q;
					`ADDR_OSC_CAL_CONFIG:           memRdata <= oscCalConfig_q;
					`ADDR_BAND_RESULT:              memRdata <= bandResult_q; // R15
					`ADDR_AMPLITUDE_RESULT:         memRdata <= amplitudeResult_q;
					default:                        memRdata <= `REG_RESET;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg         timerLoad;
	reg  [15:0] timerCount;
	wire        timerDone;
	wire        stateCmd = enterReceiveCmd | enterTransmitCmd;
	wire        cmdTransmit = enterTransmitCmd & ~enterReceiveCmd;
	wire        useBypass = bypassArmed_q & bypassConfigured;
	settle_timer phaseTimer
	(
		.clock     (clock),
		.nrst      (nrst),
		.ce        (ce),
		.load      (timerLoad),
		.loadCount (timerCount),
		.busy      (),
		.done      (timerDone)
	);
	// settling delay for the pending direction
	wire [15:0] settleCount = !customSettle ? SETTLE_COUNT : // R3 R4
		customDelay(targetTransmit_q ? txSettleDelay_q : rxSettleDelay_q); // R5 R6

	always @*
	begin
		state_d    = state_q;
		timerLoad  = 1'b0;
		timerCount = CAL_COUNT;
		case (state_q)
			`ST_IDLE, `ST_RECEIVE, `ST_TRANSMIT:
			begin
				if (sleepCmd)
					state_d = `ST_SLEEP;
				else if (stateCmd && !useBypass)
				begin
					state_d   = `ST_CAL; // R1
					timerLoad = 1'b1;
				end
				else if (stateCmd)
				begin
					state_d    = `ST_SETTLE; // R17
					timerLoad  = 1'b1;
					timerCount = !customSettle ? SETTLE_COUNT :
						customDelay(cmdTransmit ? txSettleDelay_q : rxSettleDelay_q);
				end
			end
			`ST_CAL:
			begin
				if (timerDone)
				begin
					state_d    = `ST_SETTLE; // R3
					timerLoad  = 1'b1;
					timerCount = settleCount;
				end
			end
			`ST_SETTLE:
			begin
				if (timerDone)
					state_d = targetTransmit_q ? `ST_TRANSMIT : `ST_RECEIVE; // R18
			end
			`ST_SLEEP:
			begin
				if (stateCmd)
				begin
					state_d   = `ST_CAL;
					timerLoad = 1'b1;
				end
			end
			default:
				state_d = `ST_IDLE;
		endcase
	end
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			state_q           <= `ST_IDLE;
			targetTransmit_q  <= 1'b0;
			bypassArmed_q     <= 1'b0;
			calDone_q         <= 1'b0;
			bypassed_q        <= 1'b0;
			bandResult_q      <= `REG_RESET;
			amplitudeResult_q <= `REG_RESET;
			loopBandwidth     <= `BW_RX_92K;
			seqState          <= `ST_IDLE;
			calRunning        <= 1'b0;
			receiveState      <= 1'b0;
			transmitState     <= 1'b0;
			sleepState        <= 1'b0;
			vcoBand           <= `REG_RESET;
			vcoAmplitude      <= `REG_RESET;
			gaussianEnable    <= 1'b0;
			optimizedTxBw     <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			// clear then set of the enable arms one bypassed entry
			if (calTriggerWrite && calTriggerControl_q[`BIT_SYNTH_CAL_ENABLE] == 1'b0 &&
				synthCalEnableBit)
				bypassArmed_q <= 1'b1; // R17
			else if (timerLoad && state_d == `ST_SETTLE && state_q != `ST_CAL)
				bypassArmed_q <= 1'b0;
			if (timerLoad && state_q != `ST_CAL)
			begin
				targetTransmit_q <= cmdTransmit;
				calDone_q        <= 1'b0;
				bypassed_q       <= (state_d == `ST_SETTLE);
				if (state_d == `ST_SETTLE)
				begin
					bandResult_q      <= bandOverrideValue_q; // R17
					amplitudeResult_q <= amplitudeOverrideValue_q;
					calDone_q         <= 1'b1;
				end
			end
			if (state_q == `ST_CAL && timerDone)
			begin
				calDone_q         <= 1'b1; // R2
				bandResult_q      <= calBandIn; // R15
				amplitudeResult_q <= calAmplitudeIn;
			end
			if (state_q == `ST_SETTLE && timerDone)
				loopBandwidth <= targetTransmit_q ? txBandwidth(dataRate) : // R7 R9
					`BW_RX_92K; // R8
			// outputs from flip-flops
			seqState       <= state_d;
			calRunning     <= (state_d == `ST_CAL);
			receiveState   <= (state_d == `ST_RECEIVE);
			transmitState  <= (state_d == `ST_TRANSMIT);
			sleepState     <= (state_d == `ST_SLEEP);
			vcoBand        <= bandResult_q;
			vcoAmplitude   <= amplitudeResult_q;
			gaussianEnable <= radioConfigNine_q[`BIT_GAUSSIAN_ENABLE]; // R10
			if (applyConfigCmd)
				optimizedTxBw <= (radioConfigSeven_q[`MSB_TX_BW_MODE:`LSB_TX_BW_MODE]
					== `TX_BW_MODE_OPTIMIZED); // R11
		end
	end

endmodule // synth_cal_settle_sequencer

`default_nettype wire

// *** verilog/synth_seq_map.vh ***
// address map, field positions and timing constants of the synthesizer sequencer
`ifndef SYNTH_SEQ_MAP_VH
`define SYNTH_SEQ_MAP_VH

// register addresses, 10-bit memory space
`define ADDR_RADIO_CONFIG_SEVEN      10'h113
`define ADDR_RADIO_CONFIG_NINE       10'h115
`define ADDR_OPERATING_OPTIONS       10'h11A
`define ADDR_RX_SETTLE_DELAY         10'h13E
`define ADDR_TX_SETTLE_DELAY         10'h13F
`define ADDR_CAL_TRIGGER_CONTROL     10'h338
`define ADDR_CAL_PROGRESS            10'h339
`define ADDR_BAND_OVERRIDE_VALUE     10'h3CB
`define ADDR_AMPLITUDE_OVERRIDE_VALUE 10'h3CC
`define ADDR_OVERRIDE_ENABLES        10'h3CD
`define ADDR_OSC_CAL_CONFIG          10'h3D0
`define ADDR_BAND_RESULT             10'h3DA
`define ADDR_AMPLITUDE_RESULT        10'h3DB
`define ADDR_LOOKUP_FIRST            10'h010
`define ADDR_LOOKUP_LAST             10'h018
`define LOOKUP_ENTRIES               9

// field positions
`define BIT_CUSTOM_SETTLE_ENABLE     3
`define BIT_SYNTH_CAL_ENABLE         0
`define BIT_GAUSSIAN_ENABLE          4
`define MSB_TX_BW_MODE               5
`define LSB_TX_BW_MODE               4
`define TX_BW_MODE_OPTIMIZED         2'h2
`define BIT_CAL_DONE                 0
`define BIT_CAL_BUSY                 1
`define BIT_CAL_BYPASSED             2
`define OVERRIDE_ENABLES_BYPASS      8'h03
`define OSC_CAL_CONFIG_BYPASS        8'h0F
`define REG_RESET                    8'h00

// timing
`define CLK_MHZ                      125
`define CAL_TIME_US                  142
`define SETTLE_DEFAULT_US            56
`define SETTLE_STEP_US               2

// data rate thresholds in units of 100 bps
`define RATE_LIMIT_0                 12'd495
`define RATE_LIMIT_1                 12'd1295
`define RATE_LIMIT_2                 12'd1791
`define RATE_LIMIT_3                 12'd2399

// loop bandwidth codes
`define BW_RX_92K                    3'h0
`define BW_TX_130K                   3'h1
`define BW_TX_174K                   3'h2
`define BW_TX_226K                   3'h3
`define BW_TX_305K                   3'h4
`define BW_TX_382K                   3'h5

// sequencer states
`define ST_IDLE                      3'h0
`define ST_CAL                       3'h1
`define ST_SETTLE                    3'h2
`define ST_RECEIVE                   3'h3
`define ST_TRANSMIT                  3'h4
`define ST_SLEEP                     3'h5

`endif
